// >>> src/ditl_pkg.sv
package ditl_pkg;

  localparam int CLK_NS     = 10;
  localparam int TICK_MS    = 1;
  localparam int TICK_CYC   = TICK_MS * 1000000 / CLK_NS;
  localparam int LOOP_US    = 1;
  localparam int LOOP_CYC   = LOOP_US * 1000 / CLK_NS;
  localparam int LOW_RPM    = 50;
  localparam int STOP_RPM   = 1;
  localparam int ROLL_RPM   = 10;
  localparam int DIFF_PCT   = 5;
  localparam int PCT_FULL   = 100;
  localparam int NIN        = 3;
  localparam int PI_SHIFT   = 4;

  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_SRO  = 8'h04;
  localparam logic [7:0] A_SEAT = 8'h08;
  localparam logic [7:0] A_MASK = 8'h0C;
  localparam logic [7:0] A_FWD  = 8'h10;
  localparam logic [7:0] A_REV  = 8'h14;
  localparam logic [7:0] A_THR2 = 8'h18;
  localparam logic [7:0] A_GSTD = 8'h1C;
  localparam logic [7:0] A_GLOW = 8'h20;
  localparam logic [7:0] A_GX   = 8'h24;
  localparam logic [7:0] A_LIMC = 8'h28;
  localparam logic [7:0] A_STAT = 8'h2C;
  localparam logic [7:0] A_DEM  = 8'h30;

  localparam int B_SPEED = 0;
  localparam int B_SRO   = 1;
  localparam int B_RECYC = 2;
  localparam int B_HOLD  = 3;
  localparam int B_HBRK  = 4;
  localparam int B_DUAL  = 5;
  localparam int B_VPED  = 6;
  localparam int B_PROF  = 8;
  localparam int B_KNEE  = 16;
  localparam int SEQ_POS = 0;
  localparam int CLR_POS = 8;

  localparam logic [31:0] CTRL_WM  = 32'hFFFF_037F;
  localparam logic [31:0] MASK_WM  = 32'h0000_0707;
  localparam logic [31:0] W16_WM   = 32'h0000_FFFF;
  localparam logic [31:0] W24_WM   = 32'h00FF_FFFF;
  localparam logic [31:0] CTRL_RST = 32'h0800_0000;
  localparam logic [31:0] DLY_RST  = 32'h0000_03E8;
  localparam logic [31:0] GAIN_RST = 32'h0000_1010;
  localparam logic [31:0] GX_RST   = 32'h0010_2010;
  localparam logic [31:0] LIMC_RST = 32'h0000_0FA0;

  typedef enum logic [1:0] {
    PROF_LIN   = 2'b00,
    PROF_CURVE = 2'b01,
    PROF_CRAWL = 2'b10,
    PROF_USER  = 2'b11
  } ditl_prof_t;

  typedef enum logic {
    LIM_OFF = 1'b0,
    LIM_ON  = 1'b1
  } ditl_lim_t;

  typedef struct packed {
    logic hbrake;
    logic seat;
    logic hold;
    logic rev;
    logic fwd;
    logic pedal;
  } ditl_sw_t;

  typedef struct packed {
    logic [15:0] v_end;
    logic [15:0] v_start;
  } ditl_map_t;

endpackage

// >>> src/ditl_thr_shape.sv
`timescale 1ns/1ps
module ditl_thr_shape #(
  parameter int VW = 12
) (
  input  wire logic                 [VW-1:0] volt,
  input  wire ditl_pkg::ditl_map_t           map,
  input  wire ditl_pkg::ditl_prof_t          prof,
  input  wire logic                 [VW-1:0] knee,
  output logic                      [VW-1:0] val
);
  localparam int W2 = 2 * VW;
  localparam logic [VW-1:0] FS   = '1;
  localparam logic [VW-1:0] HALF = {1'b1, {(VW-1){1'b0}}};

  logic [VW-1:0] lo;
  logic [VW-1:0] hi;
  logic [VW-1:0] d;
  logic [VW-1:0] span;
  logic [VW-1:0] x;
  logic [W2-1:0] q;
  logic [W2-1:0] sq;
  logic [W2-1:0] cu;
  logic [W2-1:0] up;

  // A falling characteristic (start above end) is mapped the same way, mirrored.
  always_comb begin
    lo   = map.v_start[VW-1:0];
    hi   = map.v_end[VW-1:0];
    d    = '0;
    span = '0;
    if (hi > lo) begin
      span = hi - lo;
      d    = (volt > hi) ? span : ((volt > lo) ? volt - lo : '0);
    end else if (lo > hi) begin
      span = lo - hi;
      d    = (volt < hi) ? span : ((volt < lo) ? lo - volt : '0);
    end
    q  = (span == '0) ? '0 : (W2'(d) * W2'(FS)) / W2'(span);
    x  = q[VW-1:0];
    sq = W2'(x) * W2'(x);
    cu = W2'(sq[W2-1:VW]) * W2'(x);
    if (!x[VW-1]) begin
      up = (W2'(x) * W2'(knee)) >> (VW - 1);
    end else begin
      up = W2'(knee) + ((W2'(x - HALF) * W2'(FS - knee)) >> (VW - 1));
    end
    unique case (prof)
      ditl_pkg::PROF_LIN:   val = x;
      ditl_pkg::PROF_CURVE: val = sq[W2-1:VW];
      ditl_pkg::PROF_CRAWL: val = cu[W2-1:VW];
      ditl_pkg::PROF_USER:  val = up[VW-1:0];
    endcase
  end

endmodule

// >>> src/ditl_top.sv
`timescale 1ns/1ps
module ditl_top #(
  parameter int VW       = 12,
  parameter int TICK_CYC = ditl_pkg::TICK_CYC
) (
  input  wire logic                    core_clk,
  input  wire logic                    sys_rst,
  input  wire logic             [7:0]  addr,
  input  wire logic             [31:0] wr_data,
  input  wire logic                    wr_en,
  input  wire logic                    rd_en,
  output logic                  [31:0] rd_data_q,
  input  wire ditl_pkg::ditl_sw_t      sw,
  input  wire logic             [VW-1:0] thr_v1,
  input  wire logic             [VW-1:0] thr_v2,
  input  wire logic signed      [15:0] speed_rpm,
  input  wire logic signed      [15:0] act_torque,
  input  wire logic                    hill_hold,
  output logic                         drive_permit_q,
  output logic                         brake_q,
  output logic signed           [15:0] torque_q,
  output logic                         seat_fault_q,
  output logic                         thr_fault_q,
  output logic                         roll_off_q
);
  localparam int W2 = 2 * VW;
  localparam int TW = $clog2(TICK_CYC + 1);
  localparam int LW = $clog2(ditl_pkg::LOOP_CYC + 1);
  localparam logic [VW-1:0] FS = '1;

  if (VW < 8 || VW > 15 || TICK_CYC < 2) begin : g_param_chk
    $error("ditl_top: VW must be 8..15 and TICK_CYC at least 2");
  end

  logic [31:0] ctrl_q, sro_dly_q, seat_dly_q, mask_q, gstd_q, glow_q, gx_q, limc_q;
  ditl_pkg::ditl_map_t fwd_q, rev_q, thr2_q, map1;
  logic [TW-1:0] tick_cnt_q;
  logic [LW-1:0] loop_cnt_q;
  logic          tick_q, loop_q;
  logic [15:0]   sro_cnt_q, seat_cnt_q;
  logic          sro_inh_q, rcy_q;
  logic [1:0]    dir_q;
  ditl_pkg::ditl_lim_t lim_q;
  logic signed [31:0] integ_q;
  logic [15:0]   mag_prev_q;
  logic [VW-1:0] v1_val, v2_val, diff, thr;
  logic          spd_mode, dir_sel, hold_ok, hbrk_on, ped, vped, big_diff, clr_ok;
  logic          sro_cond, sro_trip, rcy_set, seat_cond, seat_set, stopped, permit_d, enter;
  logic [ditl_pkg::NIN-1:0] clr_cond, clr_term;
  logic [15:0]   spd_abs, mag, spd_lim, creep;
  logic [7:0]    kp, ki;
  logic signed [31:0] err, i_step, slope, pi_sum, preset, thr_t, base, creep_t;
  logic signed [15:0] pi_sat, torque_d;

  // Register writes; CTRL, SRO, SEAT, MASK and the gain registers are masked on write, FWD, REV, THR2 and LIMC are stored as written.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      ctrl_q     <= ditl_pkg::CTRL_RST;
      sro_dly_q  <= ditl_pkg::DLY_RST;
      seat_dly_q <= ditl_pkg::DLY_RST;
      mask_q     <= '0;
      fwd_q      <= '0;
      rev_q      <= '0;
      thr2_q     <= '0;
      gstd_q     <= ditl_pkg::GAIN_RST;
      glow_q     <= ditl_pkg::GAIN_RST;
      gx_q       <= ditl_pkg::GX_RST;
      limc_q     <= ditl_pkg::LIMC_RST;
    end else if (wr_en) begin
      case (addr)
        ditl_pkg::A_CTRL: ctrl_q     <= wr_data & ditl_pkg::CTRL_WM;
        ditl_pkg::A_SRO:  sro_dly_q  <= wr_data & ditl_pkg::W16_WM;
        ditl_pkg::A_SEAT: seat_dly_q <= wr_data & ditl_pkg::W16_WM;
        ditl_pkg::A_MASK: mask_q     <= wr_data & ditl_pkg::MASK_WM;
        ditl_pkg::A_FWD:  fwd_q      <= wr_data;
        ditl_pkg::A_REV:  rev_q      <= wr_data;
        ditl_pkg::A_THR2: thr2_q     <= wr_data;
        ditl_pkg::A_GSTD: gstd_q     <= wr_data & ditl_pkg::W16_WM;
        ditl_pkg::A_GLOW: glow_q     <= wr_data & ditl_pkg::W16_WM;
        ditl_pkg::A_GX:   gx_q       <= wr_data & ditl_pkg::W24_WM;
        ditl_pkg::A_LIMC: limc_q     <= wr_data;
        default: ;
      endcase
    end
  end

  // Read data stand one cycle behind rd_en, for as long as rd_en is held; unmapped offsets read zero.
  always_ff @(posedge core_clk) begin
    if (sys_rst || !rd_en) begin
      rd_data_q <= '0;
    end else begin
      case (addr)
        ditl_pkg::A_CTRL: rd_data_q <= ctrl_q;
        ditl_pkg::A_SRO:  rd_data_q <= sro_dly_q;
        ditl_pkg::A_SEAT: rd_data_q <= seat_dly_q;
        ditl_pkg::A_MASK: rd_data_q <= mask_q;
        ditl_pkg::A_FWD:  rd_data_q <= fwd_q;
        ditl_pkg::A_REV:  rd_data_q <= rev_q;
        ditl_pkg::A_THR2: rd_data_q <= thr2_q;
        ditl_pkg::A_GSTD: rd_data_q <= gstd_q;
        ditl_pkg::A_GLOW: rd_data_q <= glow_q;
        ditl_pkg::A_GX:   rd_data_q <= gx_q;
        ditl_pkg::A_LIMC: rd_data_q <= limc_q;
        ditl_pkg::A_STAT: rd_data_q <= {24'h000000, lim_q, roll_off_q, thr_fault_q, seat_fault_q,
                                        rcy_q, sro_inh_q, brake_q, drive_permit_q};
        ditl_pkg::A_DEM:  rd_data_q <= {16'h0000, torque_q};
        default:          rd_data_q <= '0;
      endcase
    end
  end

  // Millisecond tick for the interlock delays and a faster tick for the speed loop.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      tick_cnt_q <= '0;
      tick_q     <= 1'b0;
      loop_cnt_q <= '0;
      loop_q     <= 1'b0;
    end else begin
      tick_q     <= (tick_cnt_q == TW'(TICK_CYC - 1));
      tick_cnt_q <= (tick_cnt_q == TW'(TICK_CYC - 1)) ? '0 : tick_cnt_q + 1'b1;
      loop_q     <= (loop_cnt_q == LW'(ditl_pkg::LOOP_CYC - 1));
      loop_cnt_q <= (loop_cnt_q == LW'(ditl_pkg::LOOP_CYC - 1)) ? '0 : loop_cnt_q + 1'b1;
    end
  end

  assign map1 = (sw.rev && rev_q != '0) ? rev_q : fwd_q;

  ditl_thr_shape #(.VW(VW)) u_shape1 (
    .volt (thr_v1),
    .map  (map1),
    .prof (ditl_pkg::ditl_prof_t'(ctrl_q[ditl_pkg::B_PROF +: 2])),
    .knee (ctrl_q[ditl_pkg::B_KNEE +: VW]),
    .val  (v1_val)
  );

  ditl_thr_shape #(.VW(VW)) u_shape2 (
    .volt (thr_v2),
    .map  (thr2_q),
    .prof (ditl_pkg::ditl_prof_t'(ctrl_q[ditl_pkg::B_PROF +: 2])),
    .knee (ctrl_q[ditl_pkg::B_KNEE +: VW]),
    .val  (v2_val)
  );

  assign spd_mode = ctrl_q[ditl_pkg::B_SPEED];
  assign dir_sel  = sw.fwd | sw.rev;
  assign hold_ok  = !ctrl_q[ditl_pkg::B_HOLD] | sw.hold;
  assign hbrk_on  = ctrl_q[ditl_pkg::B_HBRK] & sw.hbrake;
  assign diff     = (v1_val > v2_val) ? v1_val - v2_val : v2_val - v1_val;
  assign big_diff = ctrl_q[ditl_pkg::B_DUAL] &&
                    (W2'(diff) * W2'(ditl_pkg::PCT_FULL) > W2'(FS) * W2'(ditl_pkg::DIFF_PCT));
  // The virtual pedal closes once both throttles pass the mismatch band, so noise near zero cannot close it.
  assign vped     = (W2'(v1_val) * W2'(ditl_pkg::PCT_FULL) > W2'(FS) * W2'(ditl_pkg::DIFF_PCT)) &&
                    (W2'(v2_val) * W2'(ditl_pkg::PCT_FULL) > W2'(FS) * W2'(ditl_pkg::DIFF_PCT));
  assign ped      = (ctrl_q[ditl_pkg::B_DUAL] & ctrl_q[ditl_pkg::B_VPED]) ? vped : sw.pedal;
  assign thr      = ped ? v1_val : '0;
  assign spd_abs  = speed_rpm[15] ? 16'(-speed_rpm) : speed_rpm;
  assign stopped  = spd_abs < 16'(ditl_pkg::STOP_RPM);

  // Clearing inputs: pedal open, no direction, seat closed; each may be masked out.
  assign clr_cond = {sw.seat, !dir_sel, !ped};
  for (genvar gi = 0; gi < ditl_pkg::NIN; gi++) begin : g_clr
    assign clr_term[gi] = mask_q[ditl_pkg::CLR_POS + gi] | clr_cond[gi];
  end
  assign clr_ok = &clr_term;

  // Sequence checks use pedal and direction; masking either turns the check off.
  assign sro_cond  = ctrl_q[ditl_pkg::B_SRO] && !(|mask_q[ditl_pkg::SEQ_POS +: 2]) && ped && !dir_sel;
  assign sro_trip  = sro_cond && sro_cnt_q >= sro_dly_q[15:0];
  assign rcy_set   = ctrl_q[ditl_pkg::B_RECYC] && !(|mask_q[ditl_pkg::SEQ_POS +: 2]) &&
                     dir_sel && {sw.rev, sw.fwd} != dir_q;
  assign seat_cond = dir_sel && !sw.seat;
  assign seat_set  = seat_cond && seat_cnt_q >= seat_dly_q[15:0];

  always_ff @(posedge core_clk) begin
    if (sys_rst || !sro_cond) begin
      sro_cnt_q <= '0;
    end else if (tick_q && !sro_trip) begin
      sro_cnt_q <= sro_cnt_q + 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst || !seat_cond) begin
      seat_cnt_q <= '0;
    end else if (tick_q && !seat_set) begin
      seat_cnt_q <= seat_cnt_q + 1'b1;
    end
  end

  // Each latched inhibit is set in preference to being cleared in the same cycle.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      sro_inh_q    <= 1'b0;
      seat_fault_q <= 1'b0;
      thr_fault_q  <= 1'b0;
      rcy_q        <= 1'b0;
      dir_q        <= '0;
    end else begin
      dir_q <= {sw.rev, sw.fwd};
      if (sro_trip) sro_inh_q <= 1'b1;
      else if (clr_ok) sro_inh_q <= 1'b0;
      if (seat_set) seat_fault_q <= 1'b1;
      else if (clr_ok) seat_fault_q <= 1'b0;
      if (big_diff) thr_fault_q <= 1'b1;
      else if (clr_ok) thr_fault_q <= 1'b0;
      if (rcy_set) rcy_q <= 1'b1;
      else if (!ped) rcy_q <= 1'b0;
    end
  end

  assign permit_d = dir_sel && !(sw.fwd && sw.rev) && sw.seat && hold_ok && !hbrk_on &&
                    !sro_inh_q && !rcy_q && !rcy_set && !seat_fault_q && !thr_fault_q && !big_diff;

  // Brake: hold release brakes at once; a released pedal brakes only once stopped.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      drive_permit_q <= 1'b0;
      brake_q        <= 1'b1;
      roll_off_q     <= 1'b0;
    end else begin
      drive_permit_q <= permit_d;
      if (!hold_ok) brake_q <= 1'b1;
      else if (permit_d && ped) brake_q <= 1'b0;
      else if (stopped) brake_q <= 1'b1;
      // Roll-off ignores the handbrake on purpose: a failed handbrake must still be caught.
      roll_off_q <= !drive_permit_q && spd_abs >= 16'(ditl_pkg::ROLL_RPM);
    end
  end

  // Speed loop: target is throttle in speed mode and the speed limit in torque mode.
  assign spd_lim = limc_q[15:0];
  assign creep   = limc_q[31:16];
  assign mag     = spd_mode ? 16'(thr) : spd_lim;
  assign kp      = (spd_abs < 16'(ditl_pkg::LOW_RPM) || hill_hold) ? glow_q[7:0] : gstd_q[7:0];
  always_comb begin
    ki = (spd_abs < 16'(ditl_pkg::LOW_RPM) || hill_hold) ? glow_q[15:8] : gstd_q[15:8];
    if ((sw.fwd && speed_rpm < 0) || (sw.rev && speed_rpm > 0)) ki = gx_q[7:0];
  end
  assign err     = (sw.rev ? -32'(mag) : 32'(mag)) - 32'(speed_rpm);
  assign i_step  = err * 32'(ki);
  assign slope   = (spd_mode && mag > mag_prev_q) ?
                   (sw.rev ? -(32'(mag - mag_prev_q) * 32'(gx_q[15:8])) : 32'(mag - mag_prev_q) * 32'(gx_q[15:8]))
                   : '0;
  assign pi_sum  = (err * signed'(32'(kp)) + integ_q + slope) >>> ditl_pkg::PI_SHIFT;
  assign pi_sat  = (pi_sum > 32'sd32767) ? 16'sh7FFF : (pi_sum < -32'sd32767) ? -16'sh7FFF : pi_sum[15:0];
  assign preset  = 32'(gx_q[23:16]) * 32'(act_torque);
  assign enter   = !spd_mode && drive_permit_q && spd_abs > spd_lim;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      integ_q    <= '0;
      lim_q      <= ditl_pkg::LIM_OFF;
      mag_prev_q <= '0;
    end else if (loop_q) begin
      mag_prev_q <= mag;
      lim_q      <= enter ? ditl_pkg::LIM_ON : ditl_pkg::LIM_OFF;
      if (!drive_permit_q) integ_q <= '0;
      else if (enter && lim_q == ditl_pkg::LIM_OFF) integ_q <= preset;
      else if (spd_mode || lim_q == ditl_pkg::LIM_ON) integ_q <= integ_q + i_step;
    end
  end

  assign thr_t   = sw.rev ? -32'(thr) : 32'(thr);
  assign creep_t = sw.rev ? -32'(creep) : 32'(creep);
  always_comb begin
    if (spd_mode) base = 32'(pi_sat);
    else if (lim_q == ditl_pkg::LIM_ON) base = sw.rev ? ((thr_t > 32'(pi_sat)) ? thr_t : 32'(pi_sat)) :
                                                       ((thr_t < 32'(pi_sat)) ? thr_t : 32'(pi_sat));
    else base = thr_t;
    if (!permit_d) torque_d = '0;
    else if (!spd_mode && 16'(thr) < creep) torque_d = creep_t[15:0];
    else torque_d = base[15:0];
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) torque_q <= '0;
    else torque_q <= torque_d;
  end

  sequence s_latch_then_block(logic flag);
    flag ##1 !drive_permit_q;
  endsequence

  property p_pedal_open;
    @(posedge core_clk) disable iff (sys_rst)
      (!ped && !spd_mode && permit_d) |=> (torque_q == $past(creep_t[15:0]));
  endproperty
  a_pedal_open: assert property (p_pedal_open) else $error("open pedal gave demand other than creep");

  property p_sro;
    @(posedge core_clk) disable iff (sys_rst) sro_trip |=> s_latch_then_block(sro_inh_q);
  endproperty
  a_sro: assert property (p_sro) else $error("static return to off did not inhibit");

  property p_recycle;
    @(posedge core_clk) disable iff (sys_rst) rcy_set |=> s_latch_then_block(rcy_q);
  endproperty
  a_recycle: assert property (p_recycle) else $error("direction change did not await pedal recycle");

  property p_hold;
    @(posedge core_clk) disable iff (sys_rst) !hold_ok |=> (brake_q && !drive_permit_q);
  endproperty
  a_hold: assert property (p_hold) else $error("hold release did not brake at once");

  property p_pedal_brake;
    @(posedge core_clk) disable iff (sys_rst) (hold_ok && !ped && !stopped) |=> (brake_q == $past(brake_q));
  endproperty
  a_pedal_brake: assert property (p_pedal_brake) else $error("brake changed while still moving");

  property p_seat_open;
    @(posedge core_clk) disable iff (sys_rst) !sw.seat |=> !drive_permit_q;
  endproperty
  a_seat_open: assert property (p_seat_open) else $error("drive permitted with seat open");

  property p_seat_fault;
    @(posedge core_clk) disable iff (sys_rst) seat_set |=> s_latch_then_block(seat_fault_q);
  endproperty
  a_seat_fault: assert property (p_seat_fault) else $error("seat fault not latched");

  property p_seat_hold;
    @(posedge core_clk) disable iff (sys_rst) (seat_fault_q && !clr_ok) |=> seat_fault_q;
  endproperty
  a_seat_hold: assert property (p_seat_hold) else $error("seat fault cleared too early");

  property p_handbrake;
    @(posedge core_clk) disable iff (sys_rst) hbrk_on |=> !drive_permit_q;
  endproperty
  a_handbrake: assert property (p_handbrake) else $error("drive permitted with handbrake on");

  property p_throttle;
    @(posedge core_clk) disable iff (sys_rst) big_diff |=> (thr_fault_q && !drive_permit_q);
  endproperty
  a_throttle: assert property (p_throttle) else $error("throttle mismatch not caught");

  property p_preset;
    @(posedge core_clk) disable iff (sys_rst)
      (loop_q && drive_permit_q && enter && lim_q == ditl_pkg::LIM_OFF) |=> (integ_q == $past(preset));
  endproperty
  a_preset: assert property (p_preset) else $error("integral not preset on entering speed limit");

  property p_sro_restart;
    @(posedge core_clk) disable iff (sys_rst) !sro_cond |=> (sro_cnt_q == 16'h0000);
  endproperty
  a_sro_restart: assert property (p_sro_restart) else $error("delay counter did not restart");

endmodule

// >>> bench/ditl_vehicle.sv
`timescale 1ns/1ps
// Operator switches and conditioned analog inputs of the vehicle.
// Levels change only just after a rising edge, so the block never sees a half-made change.
module ditl_vehicle (
  input  wire logic               core_clk,
  output ditl_pkg::ditl_sw_t      sw,
  output logic             [11:0] thr_v1,
  output logic             [11:0] thr_v2,
  output logic signed      [15:0] speed_rpm,
  output logic signed      [15:0] act_torque,
  output logic                    hill_hold
);
  initial begin
    sw         = '0;
    thr_v1     = 12'h000;
    thr_v2     = 12'h000;
    speed_rpm  = 16'sh0000;
    act_torque = 16'sh0000;
    hill_hold  = 1'b0;
  end
  task set_sw(input ditl_pkg::ditl_sw_t s);
    @(posedge core_clk);
    sw <= s;
  endtask
  task set_motion(input logic signed [15:0] s, input logic signed [15:0] t, input logic h);
    @(posedge core_clk);
    speed_rpm  <= s;
    act_torque <= t;
    hill_hold  <= h;
  endtask
  task set_thr(input logic [11:0] a, input logic [11:0] b);
    @(posedge core_clk);
    thr_v1 <= a;
    thr_v2 <= b;
  endtask
endmodule

// >>> bench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic               core_clk = 1'b0;
  logic               sys_rst  = 1'b1;
  logic        [7:0]  addr     = 8'h00;
  logic        [31:0] wr_data  = 32'h0000_0000;
  logic               wr_en    = 1'b0;
  logic               rd_en    = 1'b0;
  logic        [31:0] rd_data_q;
  ditl_pkg::ditl_sw_t sw;
  logic        [11:0] thr_v1;
  logic        [11:0] thr_v2;
  logic signed [15:0] speed_rpm;
  logic signed [15:0] act_torque;
  logic signed [15:0] torque_q;
  logic               hill_hold;
  logic               drive_permit_q;
  logic               brake_q;
  logic               seat_fault_q;
  logic               thr_fault_q;
  logic               roll_off_q;
  int                 bad_count = 0;
  int                 checked   = 0;

  always #5 core_clk = ~core_clk;

  // A short tick keeps the millisecond delays within a few hundred cycles.
  ditl_top #(.VW(12), .TICK_CYC(20)) dut_u (.core_clk(core_clk), .sys_rst(sys_rst), .addr(addr),
    .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data_q(rd_data_q), .sw(sw), .thr_v1(thr_v1),
    .thr_v2(thr_v2), .speed_rpm(speed_rpm), .act_torque(act_torque), .hill_hold(hill_hold),
    .drive_permit_q(drive_permit_q), .brake_q(brake_q), .torque_q(torque_q), .seat_fault_q(seat_fault_q),
    .thr_fault_q(thr_fault_q), .roll_off_q(roll_off_q));

  ditl_vehicle veh_u (.core_clk(core_clk), .sw(sw), .thr_v1(thr_v1), .thr_v2(thr_v2),
    .speed_rpm(speed_rpm), .act_torque(act_torque), .hill_hold(hill_hold));

  task final_report;
    $display("checked=%0d bad_count=%0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    addr <= a; wr_data <= d; wr_en <= 1'b1;
    @(posedge core_clk);
    wr_en <= 1'b0;
  endtask
  task rd_chk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge core_clk);
    addr <= a; rd_en <= 1'b1;
    @(posedge core_clk);
    rd_en <= 1'b0;
    #1 chk(rd_data_q, exp);
  endtask
  task settle(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  // Waits for a fault flag to reach v; running out of cycles ends the run and is a mismatch only when v is 1.
  task wait_flag(input bit thr, input logic v);
    for (int i = 0; i < 300; i++) begin
      settle(1);
      if ((thr ? thr_fault_q : seat_fault_q) === v) return;
    end
    chk(32'h0000_0000, {31'h0, v});
    final_report();
  endtask

  task t_regs;
    chk({30'h0, drive_permit_q, brake_q}, 32'h0000_0001);
    rd_chk(ditl_pkg::A_CTRL, ditl_pkg::CTRL_RST);
    rd_chk(ditl_pkg::A_SEAT, ditl_pkg::DLY_RST);
    rd_chk(8'hFC, 32'h0000_0000);
    wr(ditl_pkg::A_SRO, 32'h1234_0005);
    rd_chk(ditl_pkg::A_SRO, 32'h0000_0005);
    $display("test regs done");
  endtask
  task t_creep;
    wr(ditl_pkg::A_LIMC, 32'h0100_0FA0);
    veh_u.set_thr(12'hFFF, 12'hFFF);
    veh_u.set_sw(6'b010010);
    settle(4);
    chk({31'h0, drive_permit_q}, 32'h0000_0001);
    chk({16'h0000, torque_q}, 32'h0000_0100);
    veh_u.set_sw(6'b010100);
    settle(4);
    chk({16'h0000, torque_q}, 32'h0000_FF00);
    $display("test creep done");
  endtask
  task t_seat;
    wr(ditl_pkg::A_SEAT, 32'h0000_0002);
    veh_u.set_sw(6'b010010);
    settle(4);
    veh_u.set_sw(6'b000010);
    settle(2);
    chk({31'h0, drive_permit_q}, 32'h0000_0000);
    wait_flag(1'b0, 1'b1);
    veh_u.set_sw(6'b010010);
    settle(8);
    chk({30'h0, seat_fault_q, drive_permit_q}, 32'h0000_0002);
    veh_u.set_sw(6'b010000);
    wait_flag(1'b0, 1'b0);
    $display("test seat done");
  endtask
  task t_dual;
    wr(ditl_pkg::A_FWD, 32'h0FFF_0000);
    wr(ditl_pkg::A_THR2, 32'h0FFF_0000);
    wr(ditl_pkg::A_CTRL, ditl_pkg::CTRL_RST | 32'h0000_0020);
    veh_u.set_sw(6'b010011);
    veh_u.set_thr(12'hFFF, 12'h000);
    wait_flag(1'b1, 1'b1);
    settle(2);
    chk({31'h0, drive_permit_q}, 32'h0000_0000);
    $display("test dual done");
  endtask
  task t_motion;
    wr(ditl_pkg::A_CTRL, ditl_pkg::CTRL_RST | 32'h0000_0018);
    wr(ditl_pkg::A_LIMC, 32'h0100_000A);
    veh_u.set_sw(6'b011000);
    veh_u.set_motion(16'sh0014, 16'sh0064, 1'b1);
    veh_u.set_sw(6'b111010);
    settle(2);
    chk({30'h0, roll_off_q, drive_permit_q}, 32'h0000_0002);
    veh_u.set_sw(6'b011011);
    settle(120);
    rd_chk(ditl_pkg::A_STAT, 32'h0000_0081);
    veh_u.set_sw(6'b011010);
    settle(2);
    chk({31'h0, brake_q}, 32'h0000_0000);
    veh_u.set_sw(6'b010010);
    settle(1);
    chk({30'h0, brake_q, drive_permit_q}, 32'h0000_0002);
    veh_u.set_sw(6'b011011);
    veh_u.set_sw(6'b011010);
    veh_u.set_motion(16'sh0000, 16'sh0000, 1'b0);
    settle(2);
    chk({31'h0, brake_q}, 32'h0000_0001);
    $display("test motion done");
  endtask
  task t_seq;
    wr(ditl_pkg::A_CTRL, ditl_pkg::CTRL_RST | 32'h0000_0006);
    wr(ditl_pkg::A_SRO, 32'h0000_0002);
    veh_u.set_sw(6'b010001);
    settle(120);
    rd_chk(ditl_pkg::A_STAT, 32'h0000_0006);
    veh_u.set_sw(6'b010011);
    rd_chk(ditl_pkg::A_STAT, 32'h0000_000E);
    veh_u.set_sw(6'b010000);
    settle(2);
    veh_u.set_sw(6'b010011);
    settle(2);
    chk({31'h0, drive_permit_q}, 32'h0000_0000);
    veh_u.set_sw(6'b010010);
    settle(3);
    chk({31'h0, drive_permit_q}, 32'h0000_0001);
    wr(ditl_pkg::A_MASK, 32'h0000_0001);
    veh_u.set_sw(6'b010101);
    settle(2);
    chk({31'h0, drive_permit_q}, 32'h0000_0001);
    chk({16'h0000, torque_q}, 32'h0000_F001);
    wr(ditl_pkg::A_CTRL, ditl_pkg::CTRL_RST | 32'h0000_0100);
    veh_u.set_thr(12'h800, 12'h800);
    settle(2);
    chk({16'h0000, torque_q}, 32'h0000_FC00);
    wr(ditl_pkg::A_CTRL, ditl_pkg::CTRL_RST | 32'h0000_0060);
    veh_u.set_sw(6'b010100);
    settle(2);
    chk({16'h0000, torque_q}, 32'h0000_F800);
    $display("test seq done");
  endtask

  initial begin
    repeat (16) @(posedge core_clk);
    sys_rst <= 1'b0;
    settle(1);
    t_regs();
    t_creep();
    t_seat();
    t_dual();
    t_motion();
    t_seq();
    final_report();
  end
endmodule
